// ---- logic/dio_map.vh ----
// constants for the direct i/o function mapper
`ifndef DIO_MAP_VH
`define DIO_MAP_VH
// function codes
`define FN_UNUSED        7'h00
`define FN_FORWARD_RUN   7'h01
`define FN_BACKWARD_RUN  7'h02
`define FN_HALT_STYLE    7'h13
`define FN_BRAKE_RELEASE 7'h14
`define FN_EXT_FAULT     7'h15
`define FN_OVERHEAT_STOP 7'h16
`define FN_FAULT_CLEAR   7'h18
`define FN_PANEL_UNLOCK  7'h1b
`define FN_GEN_FIRST     7'h20
`define FN_GEN_LAST      7'h2f
`define FN_OP_SEL_FIRST  7'h30
`define FN_OP_SEL_LAST   7'h33
`define FN_TORQUE_GATE   7'h36
`define FN_FAULT_LINE_NC 7'h41
`define FN_WARNING       7'h42
`define FN_MOVING        7'h44
`define FN_TORQUE_CAPPED 7'h47
`define FN_SPEED_REACHED 7'h4d
`define FN_INT_PROC      7'h50
`define FN_OVERLOAD      7'h51
`define FN_MAINS         7'h52
`define FN_DIRECTION     7'h54
`define FN_SHAFT_PULSE   7'h55
// register word addresses
`define REG_IN_SEL_LO    4'h0
`define REG_IN_SEL_HI    4'h1
`define REG_IN_POL       4'h2
`define REG_OUT_SEL      4'h3
`define REG_GEN_BITS     4'h4
`define REG_FUNC_STATE   4'h5
`define REG_OUT_STATE    4'h6
// reset values
`define RST_IN_SEL_LO    32'h30130201
`define RST_IN_SEL_HI    32'h00161418
`define RST_OUT_SEL      32'h00004155
`define RST_IN_POL       7'h00
`define RST_GEN_BITS     16'h0000
`endif

// ---- logic/direct_io_function_mapper.v ----
// direct input/output terminal function mapper with wishbone registers
`timescale 1ns/1ps
`include "dio_map.vh"

module direct_io_function_mapper
#(
  parameter N_IN  = 7,
  parameter N_OUT = 2
)
(
  input  wire              CLK_I,
  input  wire              NRST_I,
  input  wire              CYC_I,
  input  wire              STB_I,
  input  wire              WE_I,
  input  wire [3:0]        ADR_I,
  input  wire [3:0]        SEL_I,
  input  wire [31:0]       DAT_I,
  output wire [31:0]       DAT_O,
  output wire              ACK_O,
  input  wire [N_IN-1:0]   IN_TERM_I,
  input  wire              NET_PANEL_UNLOCK_I,
  input  wire              NET_PANEL_MAPPED_I,
  input  wire              NET_TORQUE_GATE_I,
  input  wire              NET_TORQUE_MAPPED_I,
  input  wire              FAULT_I,
  input  wire              WARNING_I,
  input  wire              MOVING_I,
  input  wire              TORQUE_CAPPED_I,
  input  wire              SPEED_REACHED_I,
  input  wire              INT_PROC_I,
  input  wire              OVERLOAD_WARN_I,
  input  wire              OVERLOAD_FAULT_I,
  input  wire              MAINS_I,
  input  wire              DIRECTION_I,
  input  wire              SHAFT_PULSE_I,
  output wire              FORWARD_RUN_O,
  output wire              BACKWARD_RUN_O,
  output wire              HALT_STYLE_O,
  output wire              BRAKE_RELEASE_O,
  output wire              EXT_FAULT_O,
  output wire              OVERHEAT_STOP_O,
  output wire              FAULT_CLEAR_O,
  output wire              PANEL_UNLOCK_O,
  output wire              TORQUE_GATE_O,
  output wire [3:0]        OP_SELECT_O,
  output wire [15:0]       GEN_BITS_O,
  output wire [N_OUT-1:0]  OUT_TERM_O
);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  reg  [N_IN-1:0] in_meta_r;
  reg  [N_IN-1:0] in_sync_r;
  reg  [14:0]     st_meta_r;
  reg  [14:0]     st_sync_r;
  wire [14:0]     st_raw;

  assign st_raw = {NET_PANEL_UNLOCK_I, NET_PANEL_MAPPED_I, NET_TORQUE_GATE_I,
                   NET_TORQUE_MAPPED_I, FAULT_I, WARNING_I, MOVING_I,
                   TORQUE_CAPPED_I, SPEED_REACHED_I, INT_PROC_I,
                   OVERLOAD_WARN_I, OVERLOAD_FAULT_I, MAINS_I,
                   DIRECTION_I, SHAFT_PULSE_I};

  // two flops per asynchronous input
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      in_meta_r <= {N_IN{1'b0}};
      in_sync_r <= {N_IN{1'b0}};
      st_meta_r <= 15'h0000;
      st_sync_r <= 15'h0000;
    end
    else
    begin
      in_meta_r <= IN_TERM_I;
      in_sync_r <= in_meta_r;
      st_meta_r <= st_raw;
      st_sync_r <= st_meta_r;
    end
  end

  wire net_pu      = st_sync_r[14];
  wire net_pu_map  = st_sync_r[13];
  wire net_tg      = st_sync_r[12];
  wire net_tg_map  = st_sync_r[11];
  wire s_fault     = st_sync_r[10];
  wire s_warn      = st_sync_r[9];
  wire s_moving    = st_sync_r[8];
  wire s_tcap      = st_sync_r[7];
  wire s_speed     = st_sync_r[6];
  wire s_busy      = st_sync_r[5];
  wire s_ol_warn   = st_sync_r[4];
  wire s_ol_fault  = st_sync_r[3];
  wire s_mains     = st_sync_r[2];
  wire s_dir       = st_sync_r[1];
  wire s_pulse     = st_sync_r[0];

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  reg  [7:0]      in_sel_r [0:N_IN-1];
  reg  [7:0]      out_sel_r [0:N_OUT-1];
  reg  [N_IN-1:0] in_pol_r;
  reg  [15:0]     gen_bits_r;
  reg             ack_r;
  reg  [31:0]     dat_r;

  wire bus_req = CYC_I & STB_I & ~ack_r;
  wire bus_wr  = bus_req & WE_I;

  // byte-lane merge of a write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          merge[b*8 +: 8] = din[b*8 +: 8];
    end
  endfunction

  wire [31:0] in_lo_w  = {in_sel_r[3], in_sel_r[2], in_sel_r[1], in_sel_r[0]};
  wire [31:0] in_hi_w  = {8'h00, in_sel_r[6], in_sel_r[5], in_sel_r[4]};
  wire [31:0] out_w    = {16'h0000, out_sel_r[1], out_sel_r[0]};
  wire [31:0] in_lo_n  = merge(in_lo_w, DAT_I, SEL_I);
  wire [31:0] in_hi_n  = merge(in_hi_w, DAT_I, SEL_I);
  wire [31:0] out_n    = merge(out_w, DAT_I, SEL_I);
  wire [31:0] pol_n    = merge({25'h0000000, in_pol_r}, DAT_I, SEL_I);
  wire [31:0] gen_n    = merge({16'h0000, gen_bits_r}, DAT_I, SEL_I);
  localparam [31:0] rst_lo  = `RST_IN_SEL_LO;
  localparam [31:0] rst_hi  = `RST_IN_SEL_HI;
  localparam [31:0] rst_out = `RST_OUT_SEL;

  // register writes, defaults at reset
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      in_sel_r[0] <= rst_lo[7:0];
      in_sel_r[1] <= rst_lo[15:8];
      in_sel_r[2] <= rst_lo[23:16];
      in_sel_r[3] <= rst_lo[31:24];
      in_sel_r[4] <= rst_hi[7:0];
      in_sel_r[5] <= rst_hi[15:8];
      in_sel_r[6] <= rst_hi[23:16];
      out_sel_r[0] <= rst_out[7:0];
      out_sel_r[1] <= rst_out[15:8];
      in_pol_r   <= `RST_IN_POL;
      gen_bits_r <= `RST_GEN_BITS;
    end
    else if (bus_wr)
    begin
      case (ADR_I)
        `REG_IN_SEL_LO:
        begin
          in_sel_r[0] <= in_lo_n[7:0];
          in_sel_r[1] <= in_lo_n[15:8];
          in_sel_r[2] <= in_lo_n[23:16];
          in_sel_r[3] <= in_lo_n[31:24];
        end
        `REG_IN_SEL_HI:
        begin
          in_sel_r[4] <= in_hi_n[7:0];
          in_sel_r[5] <= in_hi_n[15:8];
          in_sel_r[6] <= in_hi_n[23:16];
        end
        `REG_IN_POL:
          in_pol_r <= pol_n[N_IN-1:0];
        `REG_OUT_SEL:
        begin
          out_sel_r[0] <= out_n[7:0];
          out_sel_r[1] <= out_n[15:8];
        end
        `REG_GEN_BITS:
          gen_bits_r <= gen_n[15:0];
        default:
          gen_bits_r <= gen_bits_r;
      endcase
    end
  end

  // --------------------------------------------------------------
  // input function resolution
  // --------------------------------------------------------------
  wire [N_IN-1:0] act = in_sync_r ^ in_pol_r;

  // or of active terminals carrying a code
  function any_of;
    input [6:0] code;
    input [N_IN-1:0] a;
    input [8*7-1:0] sels;
    integer k;
    begin
      any_of = 1'b0;
      for (k = 0; k < 7; k = k + 1)
        if (sels[k*8 +: 7] == code && a[k])
          any_of = 1'b1;
    end
  endfunction

  // and of terminals carrying a code, and a flag whether any does
  function [1:0] all_of;
    input [6:0] code;
    input [N_IN-1:0] a;
    input [8*7-1:0] sels;
    integer k;
    begin
      all_of = 2'b10;
      for (k = 0; k < 7; k = k + 1)
        if (sels[k*8 +: 7] == code)
        begin
          all_of[0] = 1'b1;
          if (!a[k])
            all_of[1] = 1'b0;
        end
    end
  endfunction

  wire [8*7-1:0] sels = {in_hi_w[23:0], in_lo_w};
  wire [1:0] pu_w = all_of(`FN_PANEL_UNLOCK, act, sels);
  wire [1:0] tg_w = all_of(`FN_TORQUE_GATE, act, sels);

  // unused terminals never match since no function has code zero
  wire f_frun  = any_of(`FN_FORWARD_RUN, act, sels);
  wire f_bwd   = any_of(`FN_BACKWARD_RUN, act, sels);
  wire f_halt  = any_of(`FN_HALT_STYLE, act, sels);
  wire f_brake = any_of(`FN_BRAKE_RELEASE, act, sels);
  wire f_ext   = any_of(`FN_EXT_FAULT, act, sels);
  wire f_heat  = any_of(`FN_OVERHEAT_STOP, act, sels);
  wire f_clr   = any_of(`FN_FAULT_CLEAR, act, sels);
  // unmapped reads on; mapped is and with network copy
  wire f_pu    = pu_w[1] & (net_pu | ~net_pu_map);
  wire f_tg    = tg_w[1] & (net_tg | ~net_tg_map);
  wire [3:0] f_op;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_op
      assign f_op[g] = any_of(`FN_OP_SEL_FIRST + g[6:0], act, sels);
    end
  endgenerate

  // registered function states and fault-clear edge
  reg [12:0] func_r;
  reg        clr_prev_r;
  reg        clr_pulse_r;
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      func_r      <= 13'h0000;
      clr_prev_r  <= 1'b0;
      clr_pulse_r <= 1'b0;
    end
    else
    begin
      func_r      <= {f_op, f_tg, f_pu, f_heat, f_ext, f_brake, f_halt, f_bwd, f_frun, f_clr};
      clr_prev_r  <= f_clr;
      clr_pulse_r <= clr_prev_r & ~f_clr;
    end
  end

  assign FAULT_CLEAR_O   = clr_pulse_r;
  assign FORWARD_RUN_O   = func_r[1];
  assign BACKWARD_RUN_O  = func_r[2];
  assign HALT_STYLE_O    = func_r[3];
  assign BRAKE_RELEASE_O = func_r[4];
  assign EXT_FAULT_O     = func_r[5];
  assign OVERHEAT_STOP_O = func_r[6];
  assign PANEL_UNLOCK_O  = func_r[7];
  assign TORQUE_GATE_O   = func_r[8];
  assign OP_SELECT_O     = func_r[12:9];
  assign GEN_BITS_O      = gen_bits_r;

  // --------------------------------------------------------------
  // output terminal selection
  // --------------------------------------------------------------
  function out_pick;
    input [6:0]  code;
    input [12:0] fs;
    input [15:0] gb;
    input [10:0] st;
    begin
      if (code >= `FN_GEN_FIRST && code <= `FN_GEN_LAST)
        out_pick = gb[code[3:0]];
      else if (code >= `FN_OP_SEL_FIRST && code <= `FN_OP_SEL_LAST)
        out_pick = fs[9 + code[1:0]];
      else
        case (code)
          `FN_FORWARD_RUN:   out_pick = fs[1];
          `FN_BACKWARD_RUN:  out_pick = fs[2];
          `FN_HALT_STYLE:    out_pick = fs[3];
          `FN_BRAKE_RELEASE: out_pick = fs[4];
          `FN_PANEL_UNLOCK:  out_pick = fs[7];
          `FN_TORQUE_GATE:   out_pick = fs[8];
          `FN_FAULT_LINE_NC: out_pick = ~st[10];
          `FN_WARNING:       out_pick = st[9];
          `FN_MOVING:        out_pick = st[8];
          `FN_TORQUE_CAPPED: out_pick = st[7];
          `FN_SPEED_REACHED: out_pick = st[6];
          `FN_INT_PROC:      out_pick = st[5];
          `FN_OVERLOAD:      out_pick = st[4] & ~st[3];
          `FN_MAINS:         out_pick = st[2];
          `FN_DIRECTION:     out_pick = st[1];
          `FN_SHAFT_PULSE:   out_pick = st[0];
          default:           out_pick = 1'b0;
        endcase
    end
  endfunction

  reg [N_OUT-1:0] out_r;
  wire [N_OUT-1:0] out_nxt;
  generate
    for (g = 0; g < N_OUT; g = g + 1)
    begin : g_out
      assign out_nxt[g] = out_sel_r[g][7] ? 1'b0 :
                          out_pick(out_sel_r[g][6:0], func_r, gen_bits_r, st_sync_r[10:0]);
    end
  endgenerate

  // registered output terminals
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      out_r <= {N_OUT{1'b0}};
    else
      out_r <= out_nxt;
  end
  assign OUT_TERM_O = out_r;

  // --------------------------------------------------------------
  // wishbone read and ack
  // --------------------------------------------------------------
  reg [31:0] rd_nxt;
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (ADR_I)
      `REG_IN_SEL_LO:  rd_nxt = in_lo_w;
      `REG_IN_SEL_HI:  rd_nxt = in_hi_w;
      `REG_IN_POL:     rd_nxt = {25'h0000000, in_pol_r};
      `REG_OUT_SEL:    rd_nxt = out_w;
      `REG_GEN_BITS:   rd_nxt = {16'h0000, gen_bits_r};
      `REG_FUNC_STATE: rd_nxt = {19'h00000, func_r};
      `REG_OUT_STATE:  rd_nxt = {30'h00000000, out_r};
      default:         rd_nxt = 32'h00000000;
    endcase
  end

  // one wait state, ack for one cycle
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= bus_req;
      dat_r <= rd_nxt;
    end
  end
  assign ACK_O = ack_r;
  assign DAT_O = dat_r;

endmodule // direct_io_function_mapper

// ---- testbench/dio_map_properties.sv ----
// concurrent checks on the direct i/o function mapper ports
`timescale 1ns/1ps
module dio_map_checker
#(
  parameter N_IN = 7
)
(
  input wire            CLK_I,
  input wire            NRST_I,
  input wire            CYC_I,
  input wire            STB_I,
  input wire            WE_I,
  input wire            ACK_O,
  input wire [N_IN-1:0] IN_TERM_I,
  input wire            NET_PANEL_UNLOCK_I,
  input wire            NET_PANEL_MAPPED_I,
  input wire            NET_TORQUE_GATE_I,
  input wire            NET_TORQUE_MAPPED_I,
  input wire            FORWARD_RUN_O,
  input wire            BACKWARD_RUN_O,
  input wire            HALT_STYLE_O,
  input wire            BRAKE_RELEASE_O,
  input wire            EXT_FAULT_O,
  input wire            OVERHEAT_STOP_O,
  input wire            FAULT_CLEAR_O,
  input wire            PANEL_UNLOCK_O,
  input wire            TORQUE_GATE_O,
  input wire [3:0]      OP_SELECT_O,
  input wire [15:0]     GEN_BITS_O
);
  reg  [3:0]      quiet_r;
  reg  [N_IN+3:0] seen_r;
  wire [N_IN+3:0] now_w;
  // --------------------------------------------------------------
  // quiet counter: cycles without input change or bus activity
  // --------------------------------------------------------------
  assign now_w = {IN_TERM_I, NET_PANEL_UNLOCK_I, NET_PANEL_MAPPED_I,
                  NET_TORQUE_GATE_I, NET_TORQUE_MAPPED_I};
  // saturating count, cleared on any cause of output change
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      quiet_r <= 4'h0;
      seen_r  <= {(N_IN+4){1'b0}};
    end
    else
    begin
      seen_r <= now_w;
      if (now_w != seen_r || CYC_I)
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
        quiet_r <= quiet_r + 4'h1;
    end
  end
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_ack_next; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; ACK_O |-> $past(CYC_I && STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_clr_pulse; FAULT_CLEAR_O |=> !FAULT_CLEAR_O; endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("fault clear not a pulse");
  property p_gen_write; !$stable(GEN_BITS_O) |-> ACK_O && $past(WE_I); endproperty
  a_gen_write: assert property (p_gen_write) else $error("general bits moved alone");
  property p_panel_and;
    (NET_PANEL_MAPPED_I && !NET_PANEL_UNLOCK_I) [*6] |-> !PANEL_UNLOCK_O;
  endproperty
  a_panel_and: assert property (p_panel_and) else $error("panel unlock ignores net");
  property p_torque_and;
    (NET_TORQUE_MAPPED_I && !NET_TORQUE_GATE_I) [*6] |-> !TORQUE_GATE_O;
  endproperty
  a_torque_and: assert property (p_torque_and) else $error("torque gate ignores net");
  property p_quiet;
    quiet_r >= 4'h8 |-> $stable({FORWARD_RUN_O, BACKWARD_RUN_O, HALT_STYLE_O,
      BRAKE_RELEASE_O, EXT_FAULT_O, OVERHEAT_STOP_O, FAULT_CLEAR_O, PANEL_UNLOCK_O,
      TORQUE_GATE_O, OP_SELECT_O, GEN_BITS_O});
  endproperty
  a_quiet: assert property (p_quiet) else $error("function output moved without cause");
  c_write: cover property (CYC_I && WE_I && ACK_O);
  c_clear: cover property (FAULT_CLEAR_O);
  c_gate:  cover property (NET_TORQUE_MAPPED_I && !TORQUE_GATE_O);
endmodule // dio_map_checker

bind direct_io_function_mapper dio_map_checker #(.N_IN(N_IN)) chk_u (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ACK_O(ACK_O), .IN_TERM_I(IN_TERM_I), .NET_PANEL_UNLOCK_I(NET_PANEL_UNLOCK_I),
  .NET_PANEL_MAPPED_I(NET_PANEL_MAPPED_I), .NET_TORQUE_GATE_I(NET_TORQUE_GATE_I),
  .NET_TORQUE_MAPPED_I(NET_TORQUE_MAPPED_I), .FORWARD_RUN_O(FORWARD_RUN_O),
  .BACKWARD_RUN_O(BACKWARD_RUN_O), .HALT_STYLE_O(HALT_STYLE_O),
  .BRAKE_RELEASE_O(BRAKE_RELEASE_O), .EXT_FAULT_O(EXT_FAULT_O),
  .OVERHEAT_STOP_O(OVERHEAT_STOP_O), .FAULT_CLEAR_O(FAULT_CLEAR_O),
  .PANEL_UNLOCK_O(PANEL_UNLOCK_O), .TORQUE_GATE_O(TORQUE_GATE_O),
  .OP_SELECT_O(OP_SELECT_O), .GEN_BITS_O(GEN_BITS_O));

// ---- testbench/term_bank.sv ----
// switch and relay bank that energises the input terminals
`timescale 1ns/1ps
module term_bank
(
  input  wire       clk_i,
  input  wire [6:0] close_i,
  output reg  [6:0] level_o
);
  // contacts settle one clock after the controller commands them
  always @(posedge clk_i)
  begin
    level_o <= close_i;
  end
endmodule // term_bank

// ---- testbench/testbench.sv ----
// self-checking bench for the direct i/o function mapper
`timescale 1ns/1ps
`include "dio_map.vh"
module testbench;
  reg         clk, rst_n, cyc, stb, we;
  reg  [3:0]  adr, sel;
  reg  [31:0] dat, rd, lfsr;
  reg  [6:0]  close, x;
  reg  [10:0] st;
  reg  [3:0]  net;
  reg  [15:0] gen;
  integer     miscompares, n_tests, i, j, k;
  wire [31:0] dat_o;
  wire [15:0] genb;
  wire [6:0]  lvl;
  wire [3:0]  opsel;
  wire [1:0]  outt;
  wire        ack, fclr, pan, tqg, frun, bwd, halt, brk, extf, ovh;
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected output terminal level for a select code
  function e_out(input [7:0] c);
  begin
    case (c[6:0])
      `FN_FAULT_LINE_NC: e_out = !st[10];
      `FN_WARNING:       e_out = st[9];
      `FN_MOVING:        e_out = st[8];
      `FN_TORQUE_CAPPED: e_out = st[7];
      `FN_SPEED_REACHED: e_out = st[6];
      `FN_INT_PROC:      e_out = st[5];
      `FN_OVERLOAD:      e_out = st[4] & !st[3];
      `FN_MAINS:         e_out = st[2];
      `FN_DIRECTION:     e_out = st[1];
      `FN_SHAFT_PULSE:   e_out = st[0];
      `FN_FORWARD_RUN:   e_out = x[0];
      `FN_BACKWARD_RUN:  e_out = x[1];
      `FN_HALT_STYLE:    e_out = x[2];
      `FN_OP_SEL_FIRST:  e_out = x[3];
      `FN_BRAKE_RELEASE: e_out = x[5];
      `FN_TORQUE_GATE:   e_out = 1'b1;
      `FN_PANEL_UNLOCK:  e_out = 1'b1;
      default: e_out = (c[6:4] == 3'h2) ? gen[c[3:0]] : 1'b0;
    endcase
    if (c[7])
      e_out = 1'b0;
  end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // one classic wishbone cycle, bounded wait for ack
  task wb(input w, input [3:0] a, input [31:0] d);
  begin
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    k = 0;
    @(posedge clk);
    while (ack !== 1'b1 && k < 40)
    begin
      @(posedge clk);
      k = k + 1;
    end
    if (k == 40)
    begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  end
  endtask
  task settle;
    repeat (7) @(posedge clk);
  endtask
  // partner, design and clock
  term_bank bank_u (.clk_i(clk), .close_i(close), .level_o(lvl));
  direct_io_function_mapper dut_u (
    .CLK_I(clk), .NRST_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .IN_TERM_I(lvl),
    .NET_PANEL_UNLOCK_I(net[3]), .NET_PANEL_MAPPED_I(net[2]), .NET_TORQUE_GATE_I(net[1]),
    .NET_TORQUE_MAPPED_I(net[0]), .FAULT_I(st[10]), .WARNING_I(st[9]), .MOVING_I(st[8]),
    .TORQUE_CAPPED_I(st[7]), .SPEED_REACHED_I(st[6]), .INT_PROC_I(st[5]),
    .OVERLOAD_WARN_I(st[4]), .OVERLOAD_FAULT_I(st[3]), .MAINS_I(st[2]),
    .DIRECTION_I(st[1]), .SHAFT_PULSE_I(st[0]), .FORWARD_RUN_O(frun),
    .BACKWARD_RUN_O(bwd), .HALT_STYLE_O(halt), .BRAKE_RELEASE_O(brk), .EXT_FAULT_O(extf),
    .OVERHEAT_STOP_O(ovh), .FAULT_CLEAR_O(fclr), .PANEL_UNLOCK_O(pan),
    .TORQUE_GATE_O(tqg), .OP_SELECT_O(opsel), .GEN_BITS_O(genb), .OUT_TERM_O(outt));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    {rst_n, cyc, stb, we, adr, dat, close, st, net} = 0;
    sel = 4'hf;
    lfsr = 32'hd6c5;
    miscompares = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      wb(1'b0, i[3:0], 32'h0);
      chk(rd, i == 0 ? `RST_IN_SEL_LO : i == 1 ? `RST_IN_SEL_HI : i == 3 ? `RST_OUT_SEL : 0);
    end
    wb(1'b1, 4'h9, 32'hffffffff);
    wb(1'b0, 4'h9, 32'h0);
    chk(rd, 32'h0);
    st <= 11'h401;
    settle;
    chk(outt, 2'b01);
    // random terminals and polarity on the default map
    for (i = 0; i < 24; i = i + 1)
    begin
      lfsr = nxt(lfsr);
      close <= lfsr[6:0];
      wb(1'b1, `REG_IN_POL, {25'h0, lfsr[14:8]});
      x = lfsr[6:0] ^ lfsr[14:8];
      settle;
      chk({frun, bwd, halt, opsel, brk, ovh, extf, pan, tqg},
          {x[0], x[1], x[2], 3'h0, x[3], x[5], x[6], 3'b011});
    end
    wb(1'b1, `REG_IN_POL, 32'h0);
    wb(1'b1, `REG_IN_SEL_LO, 32'h31150101); // duplicate on purpose, against
    close <= 7'h0e;
    settle;
    chk({frun, bwd, extf, opsel}, 7'b1010010);
    wb(1'b0, `REG_FUNC_STATE, 32'h0);
    chk(rd, 32'h000005a2);
    wb(1'b1, `REG_IN_SEL_LO, 32'h30130200);
    close <= 7'h01;
    settle;
    chk(frun, 1'b0);
    wb(1'b1, `REG_IN_SEL_LO, `RST_IN_SEL_LO);
    close <= 7'h10;
    j = 0;
    repeat (12) @(posedge clk) j = j + (fclr === 1'b1);
    close <= 7'h00;
    repeat (12) @(posedge clk) j = j + 16 * (fclr === 1'b1);
    chk(j, 16);
    wb(1'b1, `REG_IN_SEL_HI, 32'h00361b1b);
    for (i = 0; i < 128; i = i + 1)
    begin
      close <= {i[6:4], 4'h0};
      net <= i[3:0];
      settle;
      chk({pan, tqg}, {i[4] & i[5] & (!i[2] | i[3]), i[6] & (!i[0] | i[1])});
    end
    wb(1'b1, `REG_IN_SEL_HI, `RST_IN_SEL_HI);
    net <= 4'h0;
    close <= 7'h2b;
    x = 7'h2b;
    // every output select code with random driver status
    for (j = 0; j < 256; j = j + 1)
    begin
      lfsr = nxt(lfsr);
      st <= lfsr[10:0];
      gen = lfsr[31:16];
      wb(1'b1, `REG_GEN_BITS, {16'h0, gen});
      wb(1'b1, `REG_OUT_SEL, {16'h0, j[7:0], j[7:0]});
      settle;
      chk(outt, {2{e_out(j[7:0])}});
      chk(genb, gen);
      wb(1'b0, `REG_OUT_STATE, 32'h0);
      chk(rd, {30'h0, {2{e_out(j[7:0])}}});
    end
    report_and_stop;
  end
endmodule // testbench
